// ===== hw/ccr_defines.svh
// Constants of the codec channel configuration register bank
//
// Overview of operation
// - Slot write takes tx slot, rx slot, edge
// - Edge bit zero falling, one rising transmit
// - Edge bit is one copy for both channels
// - Reserved bits written zero, read zero
// - Slot and gain reads mirror write layout
// - Gain bit seven removes PCM delay
// - Low five gain bits give scaling code
// - Code 10000 loopback, code 00000 cuts off
// - Output latch drives only pins set output
// - Pin read returns live levels of pins
// - Direction bits: zero input, one output
// - Status read: flag, active, reserved, directions
// - Power loss flag sticks until software reset
// - Active flag zero standby, one active
// - Function bit seven selects adaptive balance
// - Function bit six selects mu-law companding
// - Function bits five to two enable filters
// - Function bits one, zero enable impedance, balance
// - Adaptive balance needs balance filter enabled
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CCR_CMD_DEACTIVATE 8'h00
`define CCR_CMD_SW_RESET   8'h02
`define CCR_CMD_ACTIVATE   8'h0e
`define CCR_CMD_WR_SLOT    8'h44
`define CCR_CMD_RD_SLOT    8'h45
`define CCR_CMD_WR_GAIN    8'h50
`define CCR_CMD_RD_GAIN    8'h51
`define CCR_CMD_WR_IO_OUT  8'h52
`define CCR_CMD_RD_IO_PIN  8'h53
`define CCR_CMD_WR_IO_DIR  8'h54
`define CCR_CMD_RD_STATUS  8'h55
`define CCR_CMD_WR_OPFN    8'h60
`define CCR_CMD_RD_OPFN    8'h61

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCR_SLOT_TX_MSB    2
`define CCR_SLOT_RX_LSB    3
`define CCR_SLOT_FIELD_MSB 5
`define CCR_SLOT_EDGE_BIT  6
`define CCR_GAIN_DLY_BIT   7
`define CCR_GAIN_TXG_BIT   6
`define CCR_GAIN_RXL_BIT   5
`define CCR_GAIN_CODE_MSB  4
`define CCR_OPFN_ADPT_BIT  7
`define CCR_OPFN_MULAW_BIT 6
`define CCR_OPFN_RXGF_BIT  5
`define CCR_OPFN_TXGF_BIT  4
`define CCR_OPFN_TXEQ_BIT  3
`define CCR_OPFN_RXEQ_BIT  2
`define CCR_OPFN_IMPF_BIT  1
`define CCR_OPFN_BALF_BIT  0
`define CCR_IO_MSB         4

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define CCR_SLOT_RST       6'h00
`define CCR_EDGE_RST       1'h0
`define CCR_GAIN_RST       8'h00
`define CCR_GAIN_SWRST_LOW 7'h00
`define CCR_OPFN_RST       8'h00
`define CCR_IO_RST         5'h00
`define CCR_CODE_LOOPBACK  5'h10
`define CCR_CODE_CUTOFF    5'h00
`define CCR_CODE_OFFSET    5'h10
`define CCR_RESV_READ      1'h0
`define CCR_RSVD3_READ     3'h0

`endif

// ===== hw/ccr_pkg.sv
// Types shared by the codec channel configuration register bank
package ccr_pkg;
  typedef enum logic [0:0] {
    CCR_ST_IDLE  = 1'b0,
    CCR_ST_WDATA = 1'b1
  } ccr_state_type;

  typedef enum logic [2:0] {
    CCR_REG_NONE  = 3'b000,
    CCR_REG_SLOT  = 3'b001,
    CCR_REG_GAIN  = 3'b010,
    CCR_REG_IOOUT = 3'b011,
    CCR_REG_IODIR = 3'b100,
    CCR_REG_OPFN  = 3'b101
  } ccr_reg_type;
endpackage : ccr_pkg

// ===== hw/ccr_line_io.sv
// Line interface I/O pins of one channel: output latch gating and pin sampling
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_line_io
  import ccr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic [4:0] latch_i,
  input  wire logic [4:0] dir_i,
  input  wire logic [4:0] pin_i,
  output logic      [4:0] pin_o,
  output logic      [4:0] pin_oe_n_o,
  output logic      [4:0] level_o
);
  genvar b;
  generate
    for (b = 0; b <= `CCR_IO_MSB; b = b + 1) begin : g_pin
      // Drive only pins set as outputs; latch value stays stored
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          pin_o[b]      <= 1'b0;
          pin_oe_n_o[b] <= 1'b1;
        end else begin
          pin_o[b]      <= latch_i[b];
          pin_oe_n_o[b] <= ~dir_i[b];
        end
      end

      // Live level regardless of direction
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          level_o[b] <= 1'b0;
        end else begin
          level_o[b] <= pin_i[b];
        end
      end

      a_pin_drive: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        dir_i[b] |=> !pin_oe_n_o[b] && (pin_o[b] == $past(latch_i[b])))
        else $error("Output pin not driven from latch");
      a_pin_input: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !dir_i[b] |=> pin_oe_n_o[b])
        else $error("Input pin driven");
    end
  endgenerate
endmodule : ccr_line_io

// ===== hw/ccr_chan_regs.sv
// Register set of one codec channel
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_chan_regs
  import ccr_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        sw_reset_i,
  input  wire logic        act_set_i,
  input  wire logic        act_clr_i,
  input  wire logic        wr_en_i,
  input  ccr_reg_type      wr_reg_i,
  input  wire logic [7:0]  wr_data_i,
  output logic      [5:0]  slot_o,
  output logic      [7:0]  gain_o,
  output logic      [7:0]  opfn_o,
  output logic      [4:0]  io_out_o,
  output logic      [4:0]  io_dir_o,
  output logic             active_o
);
  // Clock slots survive software reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      slot_o <= `CCR_SLOT_RST;
    end else if (wr_en_i && wr_reg_i == CCR_REG_SLOT) begin
      slot_o <= wr_data_i[`CCR_SLOT_FIELD_MSB:0];
    end
  end

  // Gain byte; software reset clears gains and code but keeps delay bit
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      gain_o <= `CCR_GAIN_RST;
    end else if (wr_en_i && wr_reg_i == CCR_REG_GAIN) begin
      gain_o <= wr_data_i;
    end else if (sw_reset_i) begin
      gain_o <= {gain_o[`CCR_GAIN_DLY_BIT], `CCR_GAIN_SWRST_LOW};
    end
  end

  // Operating functions; software reset disables all
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      opfn_o <= `CCR_OPFN_RST;
    end else if (wr_en_i && wr_reg_i == CCR_REG_OPFN) begin
      opfn_o <= wr_data_i;
    end else if (sw_reset_i) begin
      opfn_o <= `CCR_OPFN_RST;
    end
  end

  // Output latch, kept over software reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      io_out_o <= `CCR_IO_RST;
    end else if (wr_en_i && wr_reg_i == CCR_REG_IOOUT) begin
      io_out_o <= wr_data_i[`CCR_IO_MSB:0];
    end
  end

  // Direction; software reset makes all pins inputs
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      io_dir_o <= `CCR_IO_RST;
    end else if (wr_en_i && wr_reg_i == CCR_REG_IODIR) begin
      io_dir_o <= wr_data_i[`CCR_IO_MSB:0];
    end else if (sw_reset_i) begin
      io_dir_o <= `CCR_IO_RST;
    end
  end

  // Standby after reset and software reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
    end else if (act_clr_i || sw_reset_i) begin
      active_o <= 1'b0;
    end else if (act_set_i) begin
      active_o <= 1'b1;
    end
  end
endmodule : ccr_chan_regs

// ===== hw/ccr_top.sv
// Command decoder and shared state of the dual channel configuration bank
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_top
  import ccr_pkg::*;
(
  input  wire logic            sys_clk_i,
  input  wire logic            rst_i,
  input  wire logic            byte_valid_i,
  input  wire logic [7:0]      byte_i,
  input  wire logic            chan_sel_i,
  input  wire logic            power_loss_i,
  input  wire logic [1:0][4:0] line_io_in_i,
  output logic                 rd_valid_o,
  output logic      [7:0]      rd_data_o,
  output logic      [1:0][2:0] tx_clock_slot_o,
  output logic      [1:0][2:0] rx_clock_slot_o,
  output logic                 tx_edge_select_o,
  output logic      [1:0]      pcm_delay_remove_o,
  output logic      [1:0]      tx_analog_gain_sel_o,
  output logic      [1:0]      rx_analog_loss_sel_o,
  output logic      [1:0][4:0] impedance_scaling_code_o,
  output logic      [1:0][4:0] scaling_gain_o,
  output logic      [1:0]      scaling_loopback_o,
  output logic      [1:0]      scaling_cutoff_o,
  output logic      [1:0]      adaptive_balance_sel_o,
  output logic      [1:0]      mulaw_sel_o,
  output logic      [1:0]      rx_gain_filter_en_o,
  output logic      [1:0]      tx_gain_filter_en_o,
  output logic      [1:0]      tx_equalizer_en_o,
  output logic      [1:0]      rx_equalizer_en_o,
  output logic      [1:0]      impedance_filter_en_o,
  output logic      [1:0]      balance_filter_en_o,
  output logic      [1:0]      channel_active_flag_o,
  output logic                 power_loss_flag_o,
  output logic      [1:0][4:0] line_io_out_o,
  output logic      [1:0][4:0] line_io_oe_n_o
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ccr_state_type   state_ff;
  ccr_state_type   nxt_state;
  ccr_reg_type     wreg_ff;
  ccr_reg_type     nxt_wreg;
  logic            wchan_ff;
  logic            cmd_take;
  logic            data_take;
  logic            is_read;
  logic      [7:0] nxt_rd_data;
  logic            sw_reset_any;
  logic      [1:0] sw_reset_ch;
  logic      [1:0] act_set_ch;
  logic      [1:0] act_clr_ch;
  logic      [1:0] wr_en_ch;
  logic [1:0][5:0] slot_w;
  logic [1:0][7:0] gain_w;
  logic [1:0][7:0] opfn_w;
  logic [1:0][4:0] io_out_w;
  logic [1:0][4:0] io_dir_w;
  logic      [1:0] active_w;
  logic [1:0][4:0] level_w;
  logic            edge_ff;

  // ----------------------------------------------------------------------
  // Command framing
  // ----------------------------------------------------------------------
  // Byte acceptance strobes
  assign cmd_take  = byte_valid_i && (state_ff == CCR_ST_IDLE);
  assign data_take = byte_valid_i && (state_ff == CCR_ST_WDATA);

  // Write command selects register awaiting its data byte
  always_comb begin
    nxt_wreg = CCR_REG_NONE;
    case (byte_i)
      `CCR_CMD_WR_SLOT:   nxt_wreg = CCR_REG_SLOT;
      `CCR_CMD_WR_GAIN:   nxt_wreg = CCR_REG_GAIN;
      `CCR_CMD_WR_IO_OUT: nxt_wreg = CCR_REG_IOOUT;
      `CCR_CMD_WR_IO_DIR: nxt_wreg = CCR_REG_IODIR;
      `CCR_CMD_WR_OPFN:   nxt_wreg = CCR_REG_OPFN;
      default:            nxt_wreg = CCR_REG_NONE;
    endcase
  end

  // Idle takes commands, data state takes exactly one byte
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      CCR_ST_IDLE: begin
        if (cmd_take && nxt_wreg != CCR_REG_NONE) begin
          nxt_state = CCR_ST_WDATA;
        end
      end
      CCR_ST_WDATA: begin
        if (data_take) begin
          nxt_state = CCR_ST_IDLE;
        end
      end
      default: nxt_state = CCR_ST_IDLE;
    endcase
  end

  // Framing state
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_ff <= CCR_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Target register and channel held until the data byte
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wreg_ff  <= CCR_REG_NONE;
      wchan_ff <= 1'b0;
    end else if (cmd_take) begin
      wreg_ff  <= nxt_wreg;
      wchan_ff <= chan_sel_i;
    end
  end

  // ----------------------------------------------------------------------
  // Single byte commands and write strobes
  // ----------------------------------------------------------------------
  assign sw_reset_any = cmd_take && (byte_i == `CCR_CMD_SW_RESET);
  assign sw_reset_ch  = sw_reset_any ? (chan_sel_i ? 2'b10 : 2'b01) : 2'b00;
  assign act_set_ch   = (cmd_take && byte_i == `CCR_CMD_ACTIVATE) ?
                        (chan_sel_i ? 2'b10 : 2'b01) : 2'b00;
  assign act_clr_ch   = (cmd_take && byte_i == `CCR_CMD_DEACTIVATE) ?
                        (chan_sel_i ? 2'b10 : 2'b01) : 2'b00;
  assign wr_en_ch     = data_take ? (wchan_ff ? 2'b10 : 2'b01) : 2'b00;

  // Shared transmit edge, written through either channel
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      edge_ff <= `CCR_EDGE_RST;
    end else if (data_take && wreg_ff == CCR_REG_SLOT) begin
      edge_ff <= byte_i[`CCR_SLOT_EDGE_BIT];
    end
  end

  // Power loss flag: new loss wins over a clearing reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      power_loss_flag_o <= 1'b0;
    end else if (power_loss_i) begin
      power_loss_flag_o <= 1'b1;
    end else if (sw_reset_any) begin
      power_loss_flag_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_chan
      ccr_chan_regs u_regs (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .sw_reset_i (sw_reset_ch[c]),
        .act_set_i  (act_set_ch[c]),
        .act_clr_i  (act_clr_ch[c]),
        .wr_en_i    (wr_en_ch[c]),
        .wr_reg_i   (wreg_ff),
        .wr_data_i  (byte_i),
        .slot_o     (slot_w[c]),
        .gain_o     (gain_w[c]),
        .opfn_o     (opfn_w[c]),
        .io_out_o   (io_out_w[c]),
        .io_dir_o   (io_dir_w[c]),
        .active_o   (active_w[c])
      );

      ccr_line_io u_io (
        .sys_clk_i  (sys_clk_i),
        .rst_i      (rst_i),
        .latch_i    (io_out_w[c]),
        .dir_i      (io_dir_w[c]),
        .pin_i      (line_io_in_i[c]),
        .pin_o      (line_io_out_o[c]),
        .pin_oe_n_o (line_io_oe_n_o[c]),
        .level_o    (level_w[c])
      );

      // Field fan-out straight from the channel flip-flops
      assign tx_clock_slot_o[c]          = slot_w[c][`CCR_SLOT_TX_MSB:0];
      assign rx_clock_slot_o[c]          = slot_w[c][`CCR_SLOT_FIELD_MSB:`CCR_SLOT_RX_LSB];
      assign pcm_delay_remove_o[c]       = gain_w[c][`CCR_GAIN_DLY_BIT];
      assign tx_analog_gain_sel_o[c]     = gain_w[c][`CCR_GAIN_TXG_BIT];
      assign rx_analog_loss_sel_o[c]     = gain_w[c][`CCR_GAIN_RXL_BIT];
      assign impedance_scaling_code_o[c] = gain_w[c][`CCR_GAIN_CODE_MSB:0];
      assign mulaw_sel_o[c]              = opfn_w[c][`CCR_OPFN_MULAW_BIT];
      assign rx_gain_filter_en_o[c]      = opfn_w[c][`CCR_OPFN_RXGF_BIT];
      assign tx_gain_filter_en_o[c]      = opfn_w[c][`CCR_OPFN_TXGF_BIT];
      assign tx_equalizer_en_o[c]        = opfn_w[c][`CCR_OPFN_TXEQ_BIT];
      assign rx_equalizer_en_o[c]        = opfn_w[c][`CCR_OPFN_RXEQ_BIT];
      assign impedance_filter_en_o[c]    = opfn_w[c][`CCR_OPFN_IMPF_BIT];
      assign balance_filter_en_o[c]      = opfn_w[c][`CCR_OPFN_BALF_BIT];
      assign channel_active_flag_o[c]    = active_w[c];

      // Decoded scaling network and adaptive balance controls
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          scaling_gain_o[c]         <= `CCR_CODE_CUTOFF;
          scaling_loopback_o[c]     <= 1'b0;
          scaling_cutoff_o[c]       <= 1'b0;
          adaptive_balance_sel_o[c] <= 1'b0;
        end else begin
          // Two's complement of code minus 16, in steps of 0.0625
          scaling_gain_o[c]     <= gain_w[c][`CCR_GAIN_CODE_MSB:0] - `CCR_CODE_OFFSET;
          scaling_loopback_o[c] <=
            (gain_w[c][`CCR_GAIN_CODE_MSB:0] == `CCR_CODE_LOOPBACK);
          scaling_cutoff_o[c]   <=
            (gain_w[c][`CCR_GAIN_CODE_MSB:0] == `CCR_CODE_CUTOFF);
          adaptive_balance_sel_o[c] <= opfn_w[c][`CCR_OPFN_ADPT_BIT] &&
                                       opfn_w[c][`CCR_OPFN_BALF_BIT];
        end
      end
    end
  endgenerate

  // Edge select: 0 falling, 1 rising transmit edge
  assign tx_edge_select_o = edge_ff;

  // ----------------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------------
  // Read layouts mirror writes; reserved bits read zero
  always_comb begin
    is_read     = 1'b1;
    nxt_rd_data = 8'h00;
    case (byte_i)
      `CCR_CMD_RD_SLOT:   nxt_rd_data = {`CCR_RESV_READ, edge_ff,
                                         slot_w[chan_sel_i]};
      `CCR_CMD_RD_GAIN:   nxt_rd_data = gain_w[chan_sel_i];
      `CCR_CMD_RD_IO_PIN: nxt_rd_data = {`CCR_RSVD3_READ, level_w[chan_sel_i]};
      `CCR_CMD_RD_STATUS: nxt_rd_data = {power_loss_flag_o, active_w[chan_sel_i],
                                         `CCR_RESV_READ, io_dir_w[chan_sel_i]};
      `CCR_CMD_RD_OPFN:   nxt_rd_data = opfn_w[chan_sel_i];
      default:            is_read     = 1'b0;
    endcase
  end

  // Answer byte one cycle after the read command
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= 8'h00;
    end else begin
      rd_valid_o <= cmd_take && is_read;
      if (cmd_take && is_read) begin
        rd_data_o <= nxt_rd_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_rd_cmd;
    cmd_take && is_read;
  endsequence
  sequence s_rd_answer;
    rd_valid_o;
  endsequence
  sequence s_slot_data;
    data_take && wreg_ff == CCR_REG_SLOT;
  endsequence

  a_read_answer: assert property (s_rd_cmd |=> s_rd_answer)
    else $error("Read answer missing");
  a_read_single: assert property (!(cmd_take && is_read) |=> !rd_valid_o)
    else $error("Read answer without read command");
  a_slot_readback: assert property (cmd_take && byte_i == `CCR_CMD_RD_SLOT |=>
    rd_data_o[`CCR_SLOT_EDGE_BIT] == $past(edge_ff) && !rd_data_o[7])
    else $error("Slot readback edge bit wrong");
  a_edge_shared: assert property (s_slot_data |=>
    tx_edge_select_o == $past(byte_i[`CCR_SLOT_EDGE_BIT]))
    else $error("Shared edge bit not updated");
  a_write_data: assert property (data_take && wreg_ff == CCR_REG_OPFN && !wchan_ff |=>
    opfn_w[0] == $past(byte_i))
    else $error("Operating function write lost");
  a_power_set: assert property (power_loss_i |=> power_loss_flag_o [*1])
    else $error("Power loss not flagged");
  a_power_hold: assert property (power_loss_flag_o && !sw_reset_any |=>
    power_loss_flag_o)
    else $error("Power loss flag dropped");
  a_status_read: assert property (cmd_take && byte_i == `CCR_CMD_RD_STATUS |=>
    rd_data_o[6] == $past(active_w[chan_sel_i]) && rd_data_o[7] == $past(power_loss_flag_o))
    else $error("Status read mismatch");
  a_pin_read: assert property (cmd_take && byte_i == `CCR_CMD_RD_IO_PIN |=>
    rd_data_o[4:0] == $past(level_w[chan_sel_i]))
    else $error("Pin read mismatch");
  a_loopback_code: assert property (gain_w[0][4:0] == `CCR_CODE_LOOPBACK |=>
    scaling_loopback_o[0] && !scaling_cutoff_o[0])
    else $error("Loopback code not decoded");
  a_adaptive_gate: assert property (adaptive_balance_sel_o[0] |->
    $past(opfn_w[0][`CCR_OPFN_BALF_BIT]) && $past(opfn_w[0][`CCR_OPFN_ADPT_BIT]))
    else $error("Adaptive balance without balance filter");
endmodule : ccr_top

// ===== test/ccr_host_model.sv
// Host processor model that sends command and data bytes to the bank
`timescale 1ns/1ps
module ccr_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rd_valid_i,
  input  wire logic [7:0] rd_data_i,
  output logic            byte_valid_o,
  output logic      [7:0] byte_o,
  output logic            chan_sel_o
);
  initial begin
    byte_valid_o = 1'b0;
    byte_o       = 8'h00;
    chan_sel_o   = 1'b0;
  end

  // No PCM clock comes from this model, so no rate limit is broken

  // Command byte, then optionally its data byte on the very next edge
  task automatic send(input logic c, input logic [7:0] cmd, input logic two,
                      input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    byte_valid_o = 1'b1;
    byte_o       = cmd;
    chan_sel_o   = c;
    @(posedge sys_clk_i);
    #1;
    if (two) begin
      byte_o = d & ((cmd == 8'h44) ? 8'h7f : 8'hff);
      @(posedge sys_clk_i);
      #1;
    end
    // Released lines show the inverse so stale values never look valid
    byte_valid_o = 1'b0;
    byte_o       = ~byte_o;
    chan_sel_o   = ~c;
  endtask : send

  // Read command; waits a bounded time for the answer strobe
  task automatic rd(input logic c, input logic [7:0] cmd, output logic [7:0] d,
                    output logic ok);
    send(c, cmd, 1'b0, 8'h00);
    repeat (3) begin
      if (rd_valid_i !== 1'b1) begin
        @(posedge sys_clk_i);
        #1;
      end
    end
    ok = (rd_valid_i === 1'b1);
    d  = rd_data_i;
  endtask : rd
endmodule : ccr_host_model

// ===== test/ccr_top_tb.sv
// Self-checking bench of the dual channel configuration register bank
`timescale 1ns/1ps
module ccr_top_tb
  import ccr_pkg::*;
;
  logic            sys_clk_i, rst_i, power_loss_i, byte_valid_i, chan_sel_i, rd_valid_o;
  logic            tx_edge_select_o, power_loss_flag_o;
  logic [7:0]      byte_i, rd_data_o;
  logic [1:0]      pcm_delay_remove_o, tx_analog_gain_sel_o, rx_analog_loss_sel_o;
  logic [1:0]      scaling_loopback_o, scaling_cutoff_o, adaptive_balance_sel_o, mulaw_sel_o;
  logic [1:0]      rx_gain_filter_en_o, tx_gain_filter_en_o, tx_equalizer_en_o;
  logic [1:0]      rx_equalizer_en_o, impedance_filter_en_o, balance_filter_en_o;
  logic [1:0]      channel_active_flag_o;
  logic [1:0][2:0] tx_clock_slot_o, rx_clock_slot_o;
  logic [1:0][4:0] line_io_in_i, line_io_out_o, line_io_oe_n_o, ext_lvl, dir;
  logic [1:0][4:0] impedance_scaling_code_o, scaling_gain_o;
  int              errors, check_count;

  ccr_top dut (.sys_clk_i, .rst_i, .byte_valid_i, .byte_i, .chan_sel_i, .power_loss_i,
    .line_io_in_i, .rd_valid_o, .rd_data_o, .tx_clock_slot_o, .rx_clock_slot_o,
    .tx_edge_select_o, .pcm_delay_remove_o, .tx_analog_gain_sel_o, .rx_analog_loss_sel_o,
    .impedance_scaling_code_o, .scaling_gain_o, .scaling_loopback_o, .scaling_cutoff_o,
    .adaptive_balance_sel_o, .mulaw_sel_o, .rx_gain_filter_en_o, .tx_gain_filter_en_o,
    .tx_equalizer_en_o, .rx_equalizer_en_o, .impedance_filter_en_o, .balance_filter_en_o,
    .channel_active_flag_o, .power_loss_flag_o, .line_io_out_o, .line_io_oe_n_o);
  ccr_host_model host (.sys_clk_i, .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
    .byte_valid_o(byte_valid_i), .byte_o(byte_i), .chan_sel_o(chan_sel_i));

  // Pin wire level: driven value where enabled, outside level elsewhere
  assign line_io_in_i = (~line_io_oe_n_o & line_io_out_o) | (line_io_oe_n_o & ext_lvl);

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [7:0] stat_exp(input logic f, input logic a, input logic [4:0] d);
    return {f, a, 1'b0, d};
  endfunction : stat_exp

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic c, input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    host.rd(c, cmd, d, ok);
    chk({7'h00, ok}, 8'h01, "read strobe");
    chk(d, exp, "read data");
  endtask : rdchk

  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    results();
  end

  initial begin
    logic [7:0]      d;
    logic [4:0]      code, lat;
    logic            c;
    logic [1:0][5:0] slot;
    errors = 0;
    check_count = 0;
    rst_i = 1'b1;
    power_loss_i = 1'b0;
    ext_lvl = '0;
    dir = '0;
    slot = '0;
    void'($urandom(12));
    repeat (12) @(posedge sys_clk_i);
    #1;
    rst_i = 1'b0;
    // Power-up values
    chk({3'h0, line_io_oe_n_o[0]}, 8'h1f, "pins input");
    rdchk(1'b1, 8'h51, 8'h00);
    rdchk(1'b0, 8'h61, 8'h00);
    $display("reset test done");
    // Slots and shared edge, readback of both channels; delay removed first
    host.send(1'b0, 8'h50, 1'b1, 8'h80);
    host.send(1'b1, 8'h50, 1'b1, 8'h80);
    for (int i = 0; i < 8; i++) begin
      c = 1'($urandom);
      d = 8'($urandom) & 8'h7f;
      slot[c] = d[5:0];
      host.send(c, 8'h44, 1'b1, d);
      settle();
      chk({5'h0, tx_clock_slot_o[c]}, {5'h0, d[2:0]}, "tx slot");
      chk({5'h0, rx_clock_slot_o[c]}, {5'h0, d[5:3]}, "rx slot");
      chk({7'h0, tx_edge_select_o}, {7'h0, d[6]}, "edge");
      rdchk(c, 8'h45, {1'b0, d[6], slot[c]});
      rdchk(!c, 8'h45, {1'b0, d[6], slot[!c]});
    end
    host.send(1'b0, 8'h44, 1'b1, {2'b00, slot[0]});
    $display("slot test done");
    // Gain byte with scaling code corners
    for (int i = 0; i < 7; i++) begin
      c = 1'($urandom);
      code = (i == 0) ? 5'h00 : (i == 1) ? 5'h10 : (i == 2) ? 5'h1f : 5'($urandom);
      d = {3'($urandom), code};
      host.send(c, 8'h50, 1'b1, d);
      settle();
      chk({pcm_delay_remove_o[c], tx_analog_gain_sel_o[c], rx_analog_loss_sel_o[c],
           impedance_scaling_code_o[c]}, d, "gain bits");
      chk({3'h0, scaling_gain_o[c]}, {3'h0, code - 5'h10}, "scaling");
      chk({6'h0, scaling_loopback_o[c], scaling_cutoff_o[c]},
          {6'h0, code == 5'h10, code == 5'h00}, "code modes");
      rdchk(c, 8'h51, d);
    end
    $display("gain test done");
    // Operating functions, adaptive balance gating
    for (int i = 0; i < 8; i++) begin
      c = 1'($urandom);
      d = (i == 0) ? 8'h80 : (i == 1) ? 8'h81 : 8'($urandom);
      host.send(c, 8'h60, 1'b1, d);
      settle();
      chk({adaptive_balance_sel_o[c], mulaw_sel_o[c], rx_gain_filter_en_o[c],
           tx_gain_filter_en_o[c], tx_equalizer_en_o[c], rx_equalizer_en_o[c],
           impedance_filter_en_o[c], balance_filter_en_o[c]},
          {d[7] & d[0], d[6:0]}, "functions");
      rdchk(c, 8'h61, d);
    end
    $display("function test done");
    // Line pins: latch, direction, live levels, status
    for (int i = 0; i < 6; i++) begin
      c = 1'($urandom);
      lat = 5'($urandom);
      dir[c] = 5'($urandom);
      ext_lvl = 10'($urandom);
      host.send(c, 8'h52, 1'b1, {3'h0, lat});
      host.send(c, 8'h54, 1'b1, {3'h0, dir[c]});
      settle();
      chk({3'h0, line_io_oe_n_o[c]}, {3'h0, ~dir[c]}, "direction");
      chk({3'h0, line_io_out_o[c]}, {3'h0, lat}, "latch");
      rdchk(c, 8'h53, {3'h0, (lat & dir[c]) | (ext_lvl[c] & ~dir[c])});
      rdchk(c, 8'h55, stat_exp(1'b0, 1'b0, dir[c]));
    end
    $display("pin test done");
    // Activate, power loss sticky, software reset
    host.send(1'b1, 8'h0e, 1'b0, 8'h00);
    rdchk(1'b1, 8'h55, stat_exp(1'b0, 1'b1, dir[1]));
    chk({6'h0, channel_active_flag_o}, 8'h02, "active flags");
    host.send(1'b1, 8'h00, 1'b0, 8'h00);
    rdchk(1'b1, 8'h55, stat_exp(1'b0, 1'b0, dir[1]));
    host.send(1'b1, 8'h0e, 1'b0, 8'h00);
    power_loss_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    power_loss_i = 1'b0;
    settle();
    chk({7'h0, power_loss_flag_o}, 8'h01, "power flag");
    rdchk(1'b0, 8'h55, stat_exp(1'b1, 1'b0, dir[0]));
    host.send(1'b1, 8'h02, 1'b0, 8'h00);
    settle();
    chk({5'h0, power_loss_flag_o, channel_active_flag_o}, 8'h00, "flags cleared");
    rdchk(1'b1, 8'h55, stat_exp(1'b0, 1'b0, 5'h00));
    rdchk(1'b1, 8'h61, 8'h00);
    host.send(1'b1, 8'h54, 1'b1, 8'h1f);
    settle();
    chk({3'h0, line_io_oe_n_o[1]}, 8'h00, "unused pins out");
    $display("status test done");
    results();
  end
endmodule : ccr_top_tb
